// File: hw/kbd_pkg.sv
`default_nettype none
package kbd_pkg;
  // register word indices, taken from address bits 5:2
  localparam logic [3:0] CR_IDX = 4'h0;
  localparam logic [3:0] STAT_IDX = 4'h1;
  localparam logic [3:0] DATA_IDX = 4'h2;
  localparam logic [3:0] DIV_IDX = 4'h3;
  localparam logic [3:0] IST_IDX = 4'h4;
  localparam logic [3:0] IMASK_IDX = 4'h5;
  // values after reset
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // internal state machine rate and link times
  localparam int unsigned INT_CLK_MHZ = 8;
  localparam int unsigned REQ_LOW_US = 64;
  localparam int unsigned REQ_LOW_TICKS = REQ_LOW_US * INT_CLK_MHZ;
  localparam int unsigned LINK_TMO_MS = 16;
  localparam int unsigned LINK_TMO_TICKS = LINK_TMO_MS * 1000 * INT_CLK_MHZ;
  // bit counts of one serial frame
  localparam logic [3:0] RX_STOP_BIT = 4'h9;
  localparam logic [3:0] TX_ACK_BIT = 4'hA;
  // control register fields
  typedef struct packed {
    logic en;       // interface enable
    logic data_low; // force data line low
    logic clk_low;  // force clock line low
  } ctrl_t;
  localparam ctrl_t CTRL_RST = '{en: 1'b0, data_low: 1'b0, clk_low: 1'b0};
  // interrupt bits, same layout for status and mask
  typedef struct packed {
    logic rx;  // byte received
    logic tx;  // byte sent or send timed out, buffer empty
  } irq_t;
  // link states, gray coded along idle, receive, request, send
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_TXREQ = 3'b011,
    ST_TXDATA = 3'b010
  } link_st_t;
endpackage
`default_nettype wire

// File: hw/kbd_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// two flop synchroniser, lines idle high
module kbd_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_r; // first stage, read only by second
  logic [W-1:0] sync_r; // second stage
  //////////////////////////////////////////////////////////////////////////
  // capture chain
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end
  assign o_sync = sync_r;
endmodule // kbd_sync2
`default_nettype wire

// File: hw/kbd_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
// tick every (i_div + 1) reference cycles
module kbd_tick_div #(
  parameter int unsigned W = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_div,
  output logic o_tick
);
  logic [W-1:0] cnt_r; // cycles since last tick
  logic wrap; // terminal count reached
  assign wrap = (cnt_r >= i_div);
  //////////////////////////////////////////////////////////////////////////
  // free running divider
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + 1'b1;
      o_tick <= wrap;
    end
  end
endmodule // kbd_tick_div
`default_nettype wire

// File: hw/kbd_mouse_port.sv
//Contract
//- access taken only while psel high
//- pwrite high writes, low reads
//- register chosen by address bits 5:2
//- read data driven only for reads
//- transfers timed by the bus strobe
//- reset input performs cold reset
//- rx interrupt while received byte waits
//- tx interrupt while transmit buffer empty; code asserts it only while the enable bit is set
//- send odd parity then high stop
//- received parity bit readable by software
//- software can force clock and data lines
//- software enable bit switches interface
//- one shared status register, poll or irq
//- pad drive outputs active low
//- state machines on divided internal tick
//- interface held reset while disabled
//- request: clock low 64us, then data low
//- full receiver inhibits link until read
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module kbd_mouse_port #(
  parameter int unsigned TMO_TICKS = kbd_pkg::LINK_TMO_TICKS
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_serial_clock_in,
  input wire logic i_serial_data_in,
  output logic o_clock_pad_drive_n,
  output logic o_data_pad_drive_n,
  output logic o_rx_full_irq,
  output logic o_tx_empty_irq,
  output logic o_irq
);
  //////////////////////////////////////////////////////////////////////////
  // declarations
  kbd_pkg::ctrl_t ctrl_r; // control register
  logic [3:0] div_r; // tick divisor
  logic [7:0] txd_r; // transmit byte
  logic tx_pend_r; // transmit buffer full
  logic [7:0] rxd_r; // received byte
  logic rxp_r; // received parity
  logic rx_full_r; // received byte waiting
  kbd_pkg::irq_t ist_r; // sticky events
  kbd_pkg::irq_t imask_r; // event mask
  logic [31:0] prdata_r; // read data flop
  kbd_pkg::link_st_t st_r; // link state
  logic [16:0] cnt_r; // tick timer
  logic [3:0] bit_r; // falls seen in frame
  logic [9:0] sh_r; // frame shifter
  logic drv_clk_r; // machine pulls clock low
  logic drv_dat_r; // machine pulls data low
  logic clk_prev_r; // clock at last tick
  logic tick; // internal strobe, every div_r + 1 reference cycles (8 MHz target)
  logic [1:0] pads; // synced {clock, data}
  logic cin, din; // synced line levels
  //////////////////////////////////////////////////////////////////////////
  // pad synchroniser and tick divider
  kbd_sync2 #(.W(2)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_async({i_serial_clock_in, i_serial_data_in}),
    .o_sync(pads)
  );
  assign cin = pads[1];
  assign din = pads[0];
  kbd_tick_div #(.W(4)) u_div (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_div(div_r),
    .o_tick(tick)
  );
  //////////////////////////////////////////////////////////////////////////
  // bus decode
  logic setup, acc, wr, rd; // bus phases
  logic [3:0] idx; // register index
  logic sel_cr, sel_stat, sel_data, sel_div, sel_ist, sel_imask;
  assign setup = i_psel & ~i_penable;
  assign acc = i_psel & i_penable;
  assign wr = acc & i_pwrite;
  assign rd = acc & ~i_pwrite;
  assign idx = i_paddr[5:2];
  assign sel_cr = (idx == kbd_pkg::CR_IDX);
  assign sel_stat = (idx == kbd_pkg::STAT_IDX);
  assign sel_data = (idx == kbd_pkg::DATA_IDX);
  assign sel_div = (idx == kbd_pkg::DIV_IDX);
  assign sel_ist = (idx == kbd_pkg::IST_IDX);
  assign sel_imask = (idx == kbd_pkg::IMASK_IDX);
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  //////////////////////////////////////////////////////////////////////////
  // link events and status
  logic fall; // clock line fell this tick
  logic rx_done, tx_done, tmo; // frame ends
  logic tx_busy, rx_busy;
  logic [6:0] stat; // shared status word
  assign fall = tick & clk_prev_r & ~cin;
  assign tmo = tick & (cnt_r == 17'(TMO_TICKS - 1));
  assign rx_done = (st_r == kbd_pkg::ST_RX) & fall &
                   (bit_r == kbd_pkg::RX_STOP_BIT);
  assign tx_done = (st_r == kbd_pkg::ST_TXDATA) &
                   ((fall & (bit_r == kbd_pkg::TX_ACK_BIT)) | tmo);
  assign tx_busy = (st_r == kbd_pkg::ST_TXREQ) |
                   (st_r == kbd_pkg::ST_TXDATA);
  assign rx_busy = (st_r == kbd_pkg::ST_RX);
  assign stat = {o_tx_empty_irq, tx_busy, rx_full_r, rx_busy,
                 rxp_r, din, cin};
  //////////////////////////////////////////////////////////////////////////
  // read mux
  logic [31:0] rmux;
  assign rmux = sel_cr ? {29'h0, ctrl_r} :
                sel_stat ? {25'h0, stat} :
                sel_data ? {24'h0, rxd_r} :
                sel_div ? {28'h0, div_r} :
                sel_ist ? {30'h0, ist_r} :
                sel_imask ? {30'h0, imask_r} : 32'h0;
  // read data loads in setup of a read, zero otherwise
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prdata_r <= 32'h0;
    end else begin
      prdata_r <= (setup & ~i_pwrite) ? rmux : 32'h0;
    end
  end
  assign o_prdata = prdata_r;
  //////////////////////////////////////////////////////////////////////////
  // software registers, cold reset on i_rstn
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= kbd_pkg::CTRL_RST;
      div_r <= kbd_pkg::DIV_RST;
      txd_r <= kbd_pkg::BYTE_RST;
      imask_r <= kbd_pkg::IRQ_RST;
    end else if (wr) begin
      if (sel_cr) begin
        ctrl_r <= i_pwdata[2:0];
      end
      if (sel_div) begin
        div_r <= i_pwdata[3:0];
      end
      if (sel_data) begin
        txd_r <= i_pwdata[7:0];
      end
      if (sel_imask) begin
        imask_r <= i_pwdata[1:0];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // buffer flags; hardware set wins over clear
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_pend_r <= 1'b0;
      rx_full_r <= 1'b0;
      rxd_r <= kbd_pkg::BYTE_RST;
      rxp_r <= 1'b0;
      ist_r <= kbd_pkg::IRQ_RST;
    end else begin
      if (!ctrl_r.en) begin
        tx_pend_r <= 1'b0;
      end else if (wr & sel_data) begin
        tx_pend_r <= 1'b1;
      end else if (tx_done) begin
        tx_pend_r <= 1'b0;
      end
      if (rx_done) begin
        rx_full_r <= 1'b1;
        rxd_r <= sh_r[8:1];
        rxp_r <= sh_r[9];
      end else if ((rd & sel_data) | ~ctrl_r.en) begin
        rx_full_r <= 1'b0;
      end
      ist_r <= (ist_r & ~((wr & sel_ist) ? i_pwdata[1:0] : 2'h0)) |
               {rx_done, tx_done};
    end
  end
  assign o_rx_full_irq = rx_full_r;
  assign o_tx_empty_irq = ctrl_r.en & ~tx_pend_r;
  assign o_irq = |(ist_r & imask_r);
  //////////////////////////////////////////////////////////////////////////
  // link state machine, steps on tick; forced to idle on any cycle while disabled
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= kbd_pkg::ST_IDLE;
      cnt_r <= 17'h0;
      bit_r <= 4'h0;
      sh_r <= 10'h0;
      drv_clk_r <= 1'b0;
      drv_dat_r <= 1'b0;
      clk_prev_r <= 1'b1;
    end else if (!ctrl_r.en) begin
      st_r <= kbd_pkg::ST_IDLE;
      cnt_r <= 17'h0;
      bit_r <= 4'h0;
      drv_clk_r <= 1'b0;
      drv_dat_r <= 1'b0;
      // follow the line so a forced low seen at enable is no false fall
      clk_prev_r <= cin;
    end else if (tick) begin
      clk_prev_r <= cin;
      cnt_r <= cnt_r + 17'h1;
      case (st_r)
        kbd_pkg::ST_IDLE: begin
          cnt_r <= 17'h0;
          bit_r <= 4'h0;
          if (fall & ~din & ~rx_full_r) begin
            st_r <= kbd_pkg::ST_RX; // start bit seen
          end else if (tx_pend_r & ~fall) begin
            st_r <= kbd_pkg::ST_TXREQ;
            drv_clk_r <= 1'b1;
            sh_r <= {1'b1, ~^txd_r, txd_r};
          end
        end
        kbd_pkg::ST_RX: begin
          if (tmo) begin
            st_r <= kbd_pkg::ST_IDLE; // stalled frame dropped
          end else if (fall) begin
            bit_r <= bit_r + 4'h1;
            sh_r <= {din, sh_r[9:1]};
            if (bit_r == kbd_pkg::RX_STOP_BIT) begin
              st_r <= kbd_pkg::ST_IDLE;
            end
          end
        end
        kbd_pkg::ST_TXREQ: begin
          if (cnt_r == 17'(kbd_pkg::REQ_LOW_TICKS - 1)) begin
            st_r <= kbd_pkg::ST_TXDATA;
            drv_clk_r <= 1'b0;
            drv_dat_r <= 1'b1;
            cnt_r <= 17'h0;
          end
        end
        kbd_pkg::ST_TXDATA: begin
          if (tmo) begin
            st_r <= kbd_pkg::ST_IDLE;
            drv_dat_r <= 1'b0;
          end else if (fall) begin
            bit_r <= bit_r + 4'h1;
            drv_dat_r <= ~sh_r[0];
            sh_r <= {1'b1, sh_r[9:1]};
            if (bit_r == kbd_pkg::TX_ACK_BIT) begin
              st_r <= kbd_pkg::ST_IDLE;
              drv_dat_r <= 1'b0;
            end
          end
        end
        default: begin
          st_r <= kbd_pkg::ST_IDLE;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // pad drives, low pulls the line low
  logic inhibit; // hold keyboard off while byte waits
  assign inhibit = ctrl_r.en & rx_full_r &
                   (st_r == kbd_pkg::ST_IDLE);
  assign o_clock_pad_drive_n = ~(ctrl_r.clk_low | drv_clk_r |
                                 inhibit);
  assign o_data_pad_drive_n = ~(ctrl_r.data_low | drv_dat_r);
  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);
  AST_PREADY: assert property (acc |-> o_pready)
    else $error("access not completed");
  AST_RDATA_IDLE: assert property (!i_psel |=> o_prdata == 32'h0)
    else $error("read data driven outside a read");
  AST_RX_SET: assert property (rx_done |=> o_rx_full_irq)
    else $error("rx irq missing after frame");
  AST_RX_CLR: assert property ((rd & sel_data & !rx_done)
    |=> !o_rx_full_irq)
    else $error("rx irq not cleared by data read");
  AST_TX_BUSY: assert property ((wr & sel_data & ctrl_r.en)
    |=> !o_tx_empty_irq)
    else $error("tx irq not cleared by data write");
  AST_INHIBIT: assert property ((ctrl_r.en && rx_full_r &&
    st_r == kbd_pkg::ST_IDLE) |-> !o_clock_pad_drive_n ##1
    st_r != kbd_pkg::ST_RX)
    else $error("keyboard not inhibited while full");
  AST_DISABLE: assert property (!ctrl_r.en |=> st_r == kbd_pkg::ST_IDLE)
    else $error("link active while disabled");
  AST_REQ_LOW: assert property ((st_r == kbd_pkg::ST_TXREQ)
    |-> !o_clock_pad_drive_n && o_data_pad_drive_n | ctrl_r.data_low)
    else $error("request phase lines wrong");
  AST_PARITY: assert property ($rose(st_r == kbd_pkg::ST_TXDATA)
    |-> sh_r[9] && (^sh_r[8:0]))
    else $error("frame lacks odd parity or stop");
  AST_RXP: assert property (rx_done |=> rxp_r == $past(sh_r[9]))
    else $error("rx parity not kept");
  AST_OVR: assert property (ctrl_r.data_low |-> !o_data_pad_drive_n)
    else $error("data override ignored");
endmodule // kbd_mouse_port
`default_nettype wire

// File: testbench/kbd_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// far end of the link; lines are wired-and with pull-ups
module kbd_dev_model #(
  parameter int HALF = 200
) (
  input wire logic i_clk,
  input wire logic i_clk_line,
  input wire logic i_dat_line,
  output logic o_clk,
  output logic o_dat,
  output logic [9:0] o_got,
  output int o_req_low
);
  int n; // cycles the host held the clock low
  // idle: both lines released
  initial begin
    o_clk = 1'b1;
    o_dat = 1'b1;
    o_got = '0;
    o_req_low = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // send one frame: start, d0..d7, odd parity, stop
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      o_dat <= f[i];
      repeat (HALF) @(posedge i_clk);
      o_clk <= 1'b0;
      repeat (HALF) @(posedge i_clk);
      o_clk <= 1'b1;
    end
    o_dat <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // host pulls the clock: time it, then clock in a frame if data is low
  initial forever begin
    @(posedge i_clk);
    if (!i_clk_line && o_clk) begin
      n = 0;
      while (!i_clk_line) begin
        @(posedge i_clk);
        n++;
      end
      o_req_low = n;
      if (!i_dat_line) begin
        for (int k = 0; k < 11; k++) begin
          repeat (HALF) @(posedge i_clk);
          // bit placed after the previous fall
          if (k > 0) o_got[k-1] = i_dat_line;
          // acknowledge on the eleventh fall
          if (k == 10) o_dat <= 1'b0;
          o_clk <= 1'b0;
          repeat (HALF) @(posedge i_clk);
          o_clk <= 1'b1;
        end
        repeat (HALF) @(posedge i_clk);
        o_dat <= 1'b1;
      end
    end
  end
endmodule // kbd_dev_model
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_ref_clk, i_rstn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic clk_n, dat_n, rx_irq, tx_irq, irq, dev_clk, dev_dat;
  logic [9:0] got; // stop, parity, data seen by the far end
  logic [7:0] b;
  logic [31:0] exp_q[$], msk_q[$]; // expected reads and masks
  int req_low, num_errors, check_count, seed;
  wire logic clk_line;
  wire logic dat_line;
  // open-drain lines, pulled up
  assign clk_line = clk_n & dev_clk;
  assign dat_line = dat_n & dev_dat;
  kbd_mouse_port #(.TMO_TICKS(2000)) dut_u (.i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_serial_clock_in(clk_line), .i_serial_data_in(dat_line),
    .o_clock_pad_drive_n(clk_n), .o_data_pad_drive_n(dat_n),
    .o_rx_full_irq(rx_irq), .o_tx_empty_irq(tx_irq), .o_irq(irq));
  kbd_dev_model dev_u (.i_clk(i_ref_clk), .i_clk_line(clk_line),
    .i_dat_line(dat_line), .o_clk(dev_clk), .o_dat(dev_dat),
    .o_got(got), .o_req_low(req_low));
  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  // compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    check_count++;
    if (seen !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask
  // verdict and stop
  task end_of_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one bus transfer: setup, access until pready
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    @(posedge i_ref_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        num_errors++;
        end_of_test();
      end
      @(posedge i_ref_clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read with the expectation noted for the monitor
  task rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  // bounded wait for an interrupt level
  task wt(input logic sel, input logic v);
    int n;
    n = 0;
    while ((sel ? tx_irq : rx_irq) !== v) begin
      @(negedge i_ref_clk);
      n++;
      if (n > 30000) begin
        chk("wait", 32'h0, 32'h1);
        end_of_test();
      end
    end
  endtask
  // monitor: each completed read is matched against the oldest note
  always @(posedge i_ref_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      chk("prdata", prdata & msk_q.pop_front(), exp_q.pop_front());
      chk("pslverr", {31'h0, pslverr}, 32'h0);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 54;
    num_errors = 0;
    check_count = 0;
    i_rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    @(negedge i_ref_clk);
    chk("reset", {clk_n, dat_n, rx_irq, tx_irq, irq}, 32'h18);
    rd(32'h0, 32'h0, 32'hFFFFFFFF);
    b = $random(seed);
    apb(1'b1, 32'h0C, {28'h0, b[3:0]});
    rd(32'h4C, {28'h0, b[3:0]}, 32'hFFFFFFFF);
    apb(1'b1, 32'h18, $random(seed));
    rd(32'h18, 32'h0, 32'hFFFFFFFF);
    apb(1'b1, 32'h0C, 32'h4);
    // overrides work with the interface disabled
    apb(1'b1, 32'h0, 32'h1);
    repeat (4) @(negedge i_ref_clk);
    chk("force clk", {clk_n, dat_n}, 32'h1);
    rd(32'h4, 32'h2, 32'h3);
    apb(1'b1, 32'h0, 32'h3);
    @(negedge i_ref_clk);
    chk("force both", {clk_n, dat_n}, 32'h0);
    apb(1'b1, 32'h0, 32'h4);
    @(negedge i_ref_clk);
    chk("enable", {clk_n, dat_n, tx_irq}, 32'h7);
    // receive a byte from the far end
    apb(1'b1, 32'h14, 32'h3);
    b = $random(seed);
    dev_u.send(b);
    wt(1'b0, 1'b1);
    @(negedge i_ref_clk);
    chk("inhibit", {clk_n, irq}, 32'h1);
    rd(32'h10, 32'h2, 32'h3);
    rd(32'h4, {27'h0, 1'b1, 1'b0, ~^b, 2'h0}, 32'h14);
    rd(32'h8, {24'h0, b}, 32'hFF);
    @(negedge i_ref_clk);
    chk("read clears", {rx_irq, clk_n}, 32'h1);
    apb(1'b1, 32'h14, 32'h1);
    @(negedge i_ref_clk);
    chk("masked", irq, 32'h0);
    apb(1'b1, 32'h10, 32'h2);
    rd(32'h10, 32'h0, 32'h3);
    // transmit a byte to the far end
    b = $random(seed);
    apb(1'b1, 32'h8, {24'h0, b});
    @(negedge i_ref_clk);
    chk("tx busy", tx_irq, 32'h0);
    wt(1'b1, 1'b1);
    chk("frame", got, {1'b1, ~^b, b});
    chk("req", req_low >= kbd_pkg::REQ_LOW_TICKS * 5 - 10 &&
      req_low <= kbd_pkg::REQ_LOW_TICKS * 5 + 10, 32'h1);
    @(negedge i_ref_clk);
    chk("tx irq", irq, 32'h1);
    rd(32'h10, 32'h1, 32'h3);
    apb(1'b1, 32'h0, 32'h0);
    @(negedge i_ref_clk);
    chk("disable", tx_irq, 32'h0);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
